// [acs_pkg.sv]
// Constants for the converter sequencer: register indices, fields, counts.
// Assumes a 32-bit classic Wishbone bus; register index n sits at byte 4*n.
package acs_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_MODE = 6'h00;
  localparam logic [5:0] IDX_CLKREF = 6'h02;
  localparam logic [5:0] IDX_TIMING = 6'h03;
  localparam logic [5:0] IDX_WINMODE = 6'h04;
  localparam logic [5:0] IDX_SAMPLE_LENGTH_FIELD = 6'h05;
  localparam logic [5:0] IDX_INSEL = 6'h06;
  localparam logic [5:0] IDX_COMMAND = 6'h08;
  localparam logic [5:0] IDX_EVENT = 6'h09;
  localparam logic [5:0] IDX_IRQEN = 6'h0A;
  localparam logic [5:0] IDX_FLAGS = 6'h0B;
  localparam logic [5:0] IDX_RESULT_LO = 6'h10;
  localparam logic [5:0] IDX_RESULT_HI = 6'h11;
  localparam logic [5:0] IDX_LOWER_LO = 6'h12;
  localparam logic [5:0] IDX_LOWER_HI = 6'h13;
  localparam logic [5:0] IDX_UPPER_LO = 6'h14;
  localparam logic [5:0] IDX_UPPER_HI = 6'h15;
  // ==========================================================
  // Field positions
  localparam int BIT_ENABLE = 0;
  localparam int BIT_CONT = 1;
  localparam int BIT_RES8 = 2;
  localparam int BIT_START = 0;
  localparam int BIT_EVSTART = 0;
  localparam int BIT_RDY = 0;
  localparam int BIT_WIN = 1;
  localparam int CLOCK_DIVIDE_SELECT_LSB = 0;
  localparam int REF_LSB = 4;
  // ==========================================================
  // Values after reset, codes and counts
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [5:0] CONV_CYCLES = 6'h0D;
  localparam logic [5:0] SH_CYCLES = 6'h02;
  localparam logic [4:0] TEMP_SENSOR_SEL = 5'h1E;
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [9:0] MAX_CODE = 10'h3FF;
  localparam logic [2:0] WIN_OFF = 3'h0;
  localparam logic [2:0] WIN_BELOW = 3'h1;
  localparam logic [2:0] WIN_ABOVE = 3'h2;
  localparam logic [2:0] WIN_INSIDE = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE = 3'h4;
  localparam int CLOCK_DIVIDE_SELECT_CNT_W = 8;
  typedef enum logic {ST_IDLE, ST_CONV} acs_state_t;
endpackage

// [acs_win_if.sv]
// Interface between the sequencer and its window comparator.
// Assumes the sequencer drives every operand from the same clock.
interface acs_win_if;
  logic [15:0] result;
  logic [15:0] lower;
  logic [15:0] upper;
  logic [2:0] mode;
  logic match;
  modport cmp (input result, input lower, input upper, input mode, output match);
  modport host (output result, output lower, output upper, output mode, input match);
endinterface

// [acs_prescaler.sv]
// Converter clock prescaler: one-cycle tick per converter clock rising edge.
// Assumes run_i falls when no conversion is pending or in progress.
module acs_prescaler
  import acs_pkg::*;
#(
  parameter int CNT_W = CLOCK_DIVIDE_SELECT_CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic run_i,
  input wire logic [2:0] select_i,
  output logic tick_o
);
  // ==========================================================
  // Counter
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] half;
  logic [CNT_W-1:0] wrap;
  assign half = CNT_W'(1) << select_i;
  assign wrap = (half << 1) - CNT_W'(1);
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i || !run_i) begin
      cnt_r <= '0;
    end else if (cnt_r == wrap) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= enable_i && run_i && (cnt_r == half - CNT_W'(1));
    end
  end
  // ==========================================================
  // Checks
  cnt_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !enable_i |=> (cnt_r == '0)) else $error("prescaler counts while disabled");
  tick_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !run_i |=> !tick_o) else $error("tick without a pending conversion");
endmodule

// [acs_window_cmp.sv]
// Window comparator on the fresh conversion result.
// Assumes the host only acts on match in the cycle a result completes.
module acs_window_cmp
  import acs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  acs_win_if.cmp win
);
  // ==========================================================
  // Compare
  always_comb begin
    unique case (win.mode)
      WIN_OFF: win.match = 1'b0;
      WIN_BELOW: win.match = win.result < win.lower;
      WIN_ABOVE: win.match = win.result > win.upper;
      WIN_INSIDE: win.match = (win.result > win.lower) && (win.result < win.upper);
      WIN_OUTSIDE: win.match = (win.result < win.lower) || (win.result > win.upper);
      default: win.match = 1'b0;
    endcase
  end
  // ==========================================================
  // Checks
  win_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (win.mode == WIN_OFF) |-> !win.match) else $error("match while comparator off");
  win_inside_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (win.mode == WIN_INSIDE) && win.match |-> (win.result > win.lower) && (win.result < win.upper))
    else $error("inside match outside the window");
endmodule

// [acs_top.sv]
// Conversion sequencer for a 10-bit successive-approximation converter.
// Assumes a classic Wishbone master and an analog core giving data, over-range.
module acs_top
  import acs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic event_i,
  input wire logic touch_enable_i,
  input wire logic touch_start_i,
  input wire logic [9:0] core_data_i,
  input wire logic core_over_i,
  output logic conv_tick_o,
  output logic sample_window_o,
  output logic sample_hold_o,
  output logic [4:0] channel_o,
  output logic [1:0] reference_o,
  output logic temp_sensor_on_o,
  output logic internal_ref_o,
  output logic busy_o,
  output logic result_irq_o,
  output logic window_irq_o
);
  // ==========================================================
  // Input synchronisers
  logic [13:0] s1_r;
  logic [13:0] s2_r;
  logic [1:0] s3_r;
  logic ev_edge;
  logic tch_en;
  logic tch_edge;
  logic over_s;
  logic [9:0] data_s;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 14'h0;
      s2_r <= 14'h0;
      s3_r <= 2'h0;
    end else begin
      s1_r <= {event_i, touch_enable_i, touch_start_i, core_over_i, core_data_i};
      s2_r <= s1_r;
      s3_r <= {s2_r[13], s2_r[11]};
    end
  end
  assign ev_edge = s2_r[13] & ~s3_r[1];
  assign tch_en = s2_r[12];
  assign tch_edge = s2_r[11] & ~s3_r[0];
  assign over_s = s2_r[10];
  assign data_s = s2_r[9:0];
  // ==========================================================
  // Bus decode
  logic ack_r;
  logic acc;
  logic wr;
  logic rd;
  logic [5:0] idx;
  logic [7:0] wdat;
  logic [7:0] rdata;
  assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign rd = acc & ~wb_we_i;
  assign idx = wb_adr_i[7:2];
  assign wdat = wb_dat_i[7:0];
  // ==========================================================
  // Configuration registers
  logic enable_r;
  logic cont_r;
  logic res8_r;
  logic [2:0] clock_divide_select_r;
  logic [1:0] ref_r;
  logic [3:0] dly_r;
  logic [4:0] len_r;
  logic [2:0] wmode_r;
  logic [4:0] insel_r;
  logic evctl_r;
  logic [1:0] ie_r;
  logic [15:0] lower_r;
  logic [15:0] upper_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_r <= REG_RST[BIT_ENABLE];
      cont_r <= REG_RST[BIT_CONT];
      res8_r <= REG_RST[BIT_RES8];
      clock_divide_select_r <= REG_RST[2:0];
      ref_r <= REF_INTERNAL;
      dly_r <= REG_RST[3:0];
      len_r <= REG_RST[4:0];
      wmode_r <= WIN_OFF;
      insel_r <= REG_RST[4:0];
      evctl_r <= REG_RST[BIT_EVSTART];
      ie_r <= REG_RST[1:0];
      lower_r <= {REG_RST, REG_RST};
      upper_r <= {REG_RST, REG_RST};
    end else if (wr) begin
      case (idx)
        IDX_MODE: begin
          enable_r <= wdat[BIT_ENABLE];
          cont_r <= wdat[BIT_CONT];
          res8_r <= wdat[BIT_RES8];
        end
        IDX_CLKREF: begin
          clock_divide_select_r <= wdat[CLOCK_DIVIDE_SELECT_LSB +: 3];
          ref_r <= wdat[REF_LSB +: 2];
        end
        IDX_TIMING: dly_r <= wdat[3:0];
        IDX_WINMODE: wmode_r <= wdat[2:0];
        IDX_SAMPLE_LENGTH_FIELD: len_r <= wdat[4:0];
        IDX_INSEL: insel_r <= wdat[4:0];
        IDX_EVENT: evctl_r <= wdat[BIT_EVSTART];
        IDX_IRQEN: ie_r <= wdat[1:0];
        IDX_LOWER_LO: lower_r[7:0] <= wdat;
        IDX_LOWER_HI: lower_r[15:8] <= wdat;
        IDX_UPPER_LO: upper_r[7:0] <= wdat;
        IDX_UPPER_HI: upper_r[15:8] <= wdat;
        default: begin
        end
      endcase
    end
  end
  // ==========================================================
  // Start bit
  logic start_r;
  logic trig_sw;
  logic stop_sw;
  logic trig;
  logic done;
  assign trig_sw = wr && (idx == IDX_COMMAND) && wdat[BIT_START];
  assign stop_sw = wr && (idx == IDX_COMMAND) && !wdat[BIT_START] && cont_r;
  assign trig = enable_r && (tch_en ? tch_edge : (trig_sw || (evctl_r && ev_edge)));
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_r) begin
      start_r <= 1'b0;
    end else if (trig) begin
      start_r <= 1'b1;
    end else if (done && !cont_r) begin
      start_r <= 1'b0;
    end else if (stop_sw) begin
      start_r <= 1'b0;
    end
  end
  // ==========================================================
  // Converter clock
  acs_state_t state_r;
  logic tick;
  acs_prescaler #(.CNT_W(CLOCK_DIVIDE_SELECT_CNT_W)) u_clock_divide_select (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(enable_r),
    .run_i(start_r || (state_r == ST_CONV)),
    .select_i(clock_divide_select_r),
    .tick_o(tick)
  );
  // ==========================================================
  // Conversion sequence
  logic [5:0] cyc_r;
  logic [5:0] total;
  logic [5:0] last;
  assign total = CONV_CYCLES + {2'h0, dly_r} + {1'h0, len_r};
  assign last = total - 6'h01;
  assign done = tick && (state_r == ST_CONV) && (cyc_r == last);
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_r) begin
      state_r <= ST_IDLE;
      cyc_r <= 6'h00;
    end else if (tick) begin
      unique case (state_r)
        ST_IDLE: begin
          if (start_r) begin
            state_r <= ST_CONV;
            cyc_r <= 6'h00;
          end
        end
        ST_CONV: begin
          if (cyc_r == last) begin
            cyc_r <= 6'h00;
            if (!(cont_r && start_r)) begin
              state_r <= ST_IDLE;
            end
          end else begin
            cyc_r <= cyc_r + 6'h01;
          end
        end
      endcase
    end
  end
  // ==========================================================
  // Timing strobes to the core
  logic sh_r;
  logic win_r;
  logic tick_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_r <= 1'b0;
      win_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= tick;
      sh_r <= tick && (state_r == ST_CONV) && (cyc_r == SH_CYCLES + {2'h0, dly_r} - 6'h01);
      win_r <= (state_r == ST_CONV) && (cyc_r < SH_CYCLES + {2'h0, dly_r} + {1'h0, len_r});
    end
  end
  // ==========================================================
  // Selection shadow and lock
  logic locked;
  logic [4:0] chan_r;
  logic [1:0] refa_r;
  logic temp_r;
  logic iref_r;
  assign locked = (state_r == ST_CONV) && (cyc_r != last);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_r <= REG_RST[4:0];
      refa_r <= REF_INTERNAL;
      temp_r <= 1'b0;
      iref_r <= 1'b1;
    end else if (!locked) begin
      chan_r <= insel_r;
      refa_r <= ref_r;
      temp_r <= (insel_r == TEMP_SENSOR_SEL);
      iref_r <= (ref_r == REF_INTERNAL);
    end
  end
  // ==========================================================
  // Result and window compare
  logic [9:0] raw;
  logic [15:0] res_nxt;
  logic [15:0] res_r;
  acs_win_if win_bus ();
  assign raw = over_s ? MAX_CODE : data_s;
  assign res_nxt = res8_r ? {8'h00, raw[9:2]} : {6'h00, raw};
  assign win_bus.result = res_nxt;
  assign win_bus.lower = lower_r;
  assign win_bus.upper = upper_r;
  assign win_bus.mode = wmode_r;
  acs_window_cmp u_wcmp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .win(win_bus)
  );
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_r <= {REG_RST, REG_RST};
    end else if (done) begin
      res_r <= res_nxt;
    end
  end
  // ==========================================================
  // Flags and requests
  logic rdy_r;
  logic wflag_r;
  logic rd_res;
  logic w1c;
  assign rd_res = rd && ((idx == IDX_RESULT_LO) || (idx == IDX_RESULT_HI));
  assign w1c = wr && (idx == IDX_FLAGS);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_r <= 1'b0;
    end else if (done) begin
      rdy_r <= 1'b1;
    end else if (rd_res || (w1c && wdat[BIT_RDY])) begin
      rdy_r <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wflag_r <= 1'b0;
    end else if (done && win_bus.match) begin
      wflag_r <= 1'b1;
    end else if (w1c && wdat[BIT_WIN]) begin
      wflag_r <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_irq_o <= 1'b0;
      window_irq_o <= 1'b0;
    end else begin
      result_irq_o <= rdy_r && ie_r[BIT_RDY];
      window_irq_o <= wflag_r && ie_r[BIT_WIN];
    end
  end
  // ==========================================================
  // Read mux and bus answer
  always_comb begin
    case (idx)
      IDX_MODE: rdata = {5'h00, res8_r, cont_r, enable_r};
      IDX_CLKREF: rdata = {2'h0, ref_r, 1'h0, clock_divide_select_r};
      IDX_TIMING: rdata = {4'h0, dly_r};
      IDX_WINMODE: rdata = {5'h00, wmode_r};
      IDX_SAMPLE_LENGTH_FIELD: rdata = {3'h0, len_r};
      IDX_INSEL: rdata = {3'h0, insel_r};
      IDX_COMMAND: rdata = {7'h00, start_r};
      IDX_EVENT: rdata = {7'h00, evctl_r};
      IDX_IRQEN: rdata = {6'h00, ie_r};
      IDX_FLAGS: rdata = {6'h00, wflag_r, rdy_r};
      IDX_RESULT_LO: rdata = res_r[7:0];
      IDX_RESULT_HI: rdata = res_r[15:8];
      IDX_LOWER_LO: rdata = lower_r[7:0];
      IDX_LOWER_HI: rdata = lower_r[15:8];
      IDX_UPPER_LO: rdata = upper_r[7:0];
      IDX_UPPER_HI: rdata = upper_r[15:8];
      default: rdata = 8'h00;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_r <= acc;
      if (rd) begin
        wb_dat_o <= {24'h000000, rdata};
      end
    end
  end
  // ==========================================================
  // Output registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= start_r || (state_r == ST_CONV);
    end
  end
  assign wb_ack_o = ack_r;
  assign conv_tick_o = tick_r;
  assign sample_hold_o = sh_r;
  assign sample_window_o = win_r;
  assign channel_o = chan_r;
  assign reference_o = refa_r;
  assign temp_sensor_on_o = temp_r;
  assign internal_ref_o = iref_r;
  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  start_edge_a: assert property ((state_r == ST_IDLE) && start_r && tick && enable_r
    |=> state_r == ST_CONV) else $error("conversion did not start on tick");
  idle_tick_a: assert property ($rose(start_r) && (state_r == ST_IDLE) |-> !tick)
    else $error("prescaler not reset before start");
  plain_len_a: assert property (done && (dly_r == 4'h0) && (len_r == 5'h00)
    |-> cyc_r == CONV_CYCLES - 6'h01) else $error("plain conversion length wrong");
  hold_time_a: assert property (sh_r |-> cyc_r == SH_CYCLES + {2'h0, dly_r})
    else $error("sample-and-hold at wrong cycle");
  ready_set_a: assert property (done |=> rdy_r && (res_r == $past(res_nxt)))
    else $error("completion did not store result");
  ready_clr_a: assert property (rdy_r && rd_res && !done |=> !rdy_r)
    else $error("result read did not clear ready");
  free_run_a: assert property (done && cont_r && start_r
    |=> (state_r == ST_CONV) && (cyc_r == 6'h00)) else $error("no restart");
  sel_lock_a: assert property (locked |=> $stable(chan_r) && $stable(refa_r))
    else $error("selection changed while locked");
  over_clamp_a: assert property (done && over_s && !res8_r |=> res_r == {6'h00, MAX_CODE})
    else $error("over-range not clamped");
  win_irq_a: assert property (!ie_r[BIT_WIN] |=> !window_irq_o)
    else $error("window request while disabled");
  touch_own_a: assert property (tch_en && !tch_edge && !start_r |=> !start_r)
    else $error("start taken while touch owns converter");
  single_clr_a: assert property (done && !cont_r && !trig |=> !start_r)
    else $error("start bit not cleared");
  narrow_a: assert property (done && res8_r |=> res_r[15:8] == 8'h00)
    else $error("eight-bit result too wide");
  single_c: cover property (done && !cont_r);
  restart_c: cover property (done && cont_r && start_r);
  match_c: cover property (done && win_bus.match);
  event_c: cover property (evctl_r && ev_edge && enable_r);
endmodule

// [acs_core_model.sv]
// Stand-in for the analog core: turns the active input into a code.
// Assumes the sequencer pulses sample_hold_i once per conversion.
module acs_core_model (
  input wire logic clk_i,
  input wire logic [4:0] channel_i,
  input wire logic sample_hold_i,
  output logic [9:0] data_o,
  output logic over_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Held sample, input 0x1F stands for an overdriven pin
  initial begin
    data_o = 10'h000;
    over_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (sample_hold_i) begin
      data_o <= {channel_i, 5'h15};
      over_o <= (channel_i == 5'h1F);
    end
  end
endmodule

// [tb.sv]
// Self-checking bench for the converter sequencer over classic Wishbone.
// Assumes acs_core_model as the analog core and the register map of acs_pkg.
module tb
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic ev = 1'b0;
  logic ten = 1'b0;
  logic tst = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack, tick, win, sh, temp, iref, busy, rirq, wirq, over, win_q, irq_q;
  logic [9:0] cdat;
  logic [4:0] ch;
  logic [1:0] refs;
  logic [7:0] r, lo;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc_n = 0;
  int t_wr, t_wf, t_sh, t_rdy, t_ack, n_tk;
  acs_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .event_i(ev), .touch_enable_i(ten), .touch_start_i(tst),
    .core_data_i(cdat), .core_over_i(over), .conv_tick_o(tick),
    .sample_window_o(win), .sample_hold_o(sh), .channel_o(ch), .reference_o(refs),
    .temp_sensor_on_o(temp), .internal_ref_o(iref), .busy_o(busy),
    .result_irq_o(rirq), .window_irq_o(wirq));
  acs_core_model core_u (.clk_i(clk_i), .channel_i(ch), .sample_hold_i(sh),
    .data_o(cdat), .over_o(over));
  initial forever #2.5 clk_i = ~clk_i;
  // ==========================================================
  // Edge timestamps
  always @(posedge clk_i) begin
    cyc_n++;
    if (win && !win_q) t_wr = cyc_n;
    if (!win && win_q) t_wf = cyc_n;
    if (sh) t_sh = cyc_n;
    if (tick) n_tk++;
    if (rirq && !irq_q) t_rdy = cyc_n;
    if (ack && we) t_ack = cyc_n;
    win_q = win;
    irq_q = rirq;
  end
  // ==========================================================
  // Checks and bus cycles
  task chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    chk({15'h0, g}, {15'h0, e});
  endtask
  task acc(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task wait_rdy();
    for (int k = 0; k < 300; k++) begin
      acc(1'b0, IDX_FLAGS, 8'h00);
      if (r[BIT_RDY] === 1'b1) break;
    end
  endtask
  task get(input logic [15:0] e);
    wait_rdy();
    acc(1'b0, IDX_RESULT_LO, 8'h00);
    lo = r;
    acc(1'b0, IDX_RESULT_HI, 8'h00);
    chk({r, lo}, e);
  endtask
  function automatic logic [15:0] code(input logic [4:0] c);
    code = (c == 5'h1F) ? 16'h03FF : {6'h00, c, 5'h15};
  endfunction
  task meas(input int p, input int d, input int l);
    int f;
    f = 1 << (p + 1);
    acc(1'b1, IDX_CLKREF, 8'(p));
    acc(1'b1, IDX_TIMING, 8'(d));
    acc(1'b1, IDX_SAMPLE_LENGTH_FIELD, 8'(l));
    n_tk = 0;
    acc(1'b1, IDX_COMMAND, 8'h01);
    get(code(5'h0C));
    chk(16'(t_wr - t_ack), 16'(f / 2 + 2));
    // Window output rises one cycle after the start tick
    chk(16'(t_sh - t_wr), 16'((2 + d) * f - 1));
    chk(16'(t_wf - t_wr), 16'((2 + d + l) * f));
    chk(16'(t_rdy - t_wr), 16'((13 + d + l) * f));
    chk(16'(n_tk), 16'(14 + d + l));
    acc(1'b0, IDX_FLAGS, 8'h00);
    chk1(r[BIT_RDY], 1'b0);
  endtask
  task finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    logic [2:0] wm [5];
    logic [4:0] cs [3];
    logic [15:0] v;
    logic e;
    wm = '{WIN_OFF, WIN_BELOW, WIN_ABOVE, WIN_INSIDE, WIN_OUTSIDE};
    cs = '{5'h03, 5'h0C, 5'h1F};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    chk1(iref, 1'b1);
    acc(1'b0, 6'h3F, 8'h00);
    chk({8'h00, r}, 16'h0000);
    acc(1'b1, IDX_CLKREF, 8'h10);
    acc(1'b1, IDX_INSEL, 8'h1E);
    repeat (3) @(posedge clk_i);
    chk1(iref, 1'b0);
    chk1(temp, 1'b1);
    acc(1'b1, IDX_CLKREF, 8'h00);
    acc(1'b1, IDX_INSEL, 8'h0C);
    repeat (3) @(posedge clk_i);
    chk({14'h0, refs}, 16'h0000);
    chk({11'h0, ch}, 16'h000C);
    acc(1'b1, IDX_IRQEN, 8'h03);
    acc(1'b1, IDX_MODE, 8'h01);
    meas(0, 0, 0);
    meas(2, 1, 2);
    acc(1'b1, IDX_COMMAND, 8'h01);
    acc(1'b0, IDX_COMMAND, 8'h00);
    chk1(r[BIT_START], 1'b1);
    wait_rdy();
    chk1(r[BIT_RDY], 1'b1);
    acc(1'b0, IDX_COMMAND, 8'h00);
    chk1(r[BIT_START], 1'b0);
    acc(1'b1, IDX_FLAGS, 8'h01);
    acc(1'b0, IDX_FLAGS, 8'h00);
    chk1(r[BIT_RDY], 1'b0);
    acc(1'b1, IDX_MODE, 8'h05);
    acc(1'b1, IDX_COMMAND, 8'h01);
    get(code(5'h0C) >> 2);
    acc(1'b1, IDX_INSEL, 8'h03);
    acc(1'b1, IDX_MODE, 8'h03);
    acc(1'b1, IDX_COMMAND, 8'h01);
    repeat (20) @(posedge clk_i);
    acc(1'b1, IDX_INSEL, 8'h0C);
    repeat (2) @(posedge clk_i);
    chk({11'h0, ch}, 16'h0003);
    get(code(5'h03));
    get(code(5'h0C));
    acc(1'b1, IDX_COMMAND, 8'h00);
    acc(1'b1, IDX_MODE, 8'h01);
    repeat (300) @(posedge clk_i);
    chk1(busy, 1'b0);
    acc(1'b1, IDX_FLAGS, 8'h03);
    acc(1'b1, IDX_LOWER_HI, 8'h01);
    acc(1'b1, IDX_UPPER_HI, 8'h02);
    foreach (wm[m]) begin
      foreach (cs[c]) begin
        v = code(cs[c]);
        e = (m == 1) ? (v < 16'h0100) : (m == 2) ? (v > 16'h0200) :
            (m == 3) ? (v > 16'h0100 && v < 16'h0200) :
            (m == 4) ? (v < 16'h0100 || v > 16'h0200) : 1'b0;
        acc(1'b1, IDX_WINMODE, {5'h00, wm[m]});
        acc(1'b1, IDX_INSEL, {3'h0, cs[c]});
        acc(1'b1, IDX_COMMAND, 8'h01);
        get(v);
        acc(1'b0, IDX_FLAGS, 8'h00);
        chk1(r[BIT_WIN], e);
        chk1(wirq, e);
        acc(1'b1, IDX_FLAGS, 8'h03);
      end
    end
    acc(1'b1, IDX_IRQEN, 8'h01);
    acc(1'b1, IDX_COMMAND, 8'h01);
    get(code(5'h1F));
    chk1(wirq, 1'b0);
    acc(1'b1, IDX_EVENT, 8'h01);
    ev <= 1'b1;
    repeat (4) @(posedge clk_i);
    ev <= 1'b0;
    get(code(5'h1F));
    acc(1'b1, IDX_EVENT, 8'h00);
    ten <= 1'b1;
    repeat (4) @(posedge clk_i);
    acc(1'b1, IDX_COMMAND, 8'h01);
    repeat (100) @(posedge clk_i);
    chk1(busy, 1'b0);
    tst <= 1'b1;
    get(code(5'h1F));
    tst <= 1'b0;
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    finish_test();
  end
endmodule
